// *** ptrc_pkg.sv ***
// Purpose: shared constants and types of the packet and timing recovery configuration bank
// Assumes: 8-bit registers, one per aligned 32-bit Wishbone word, byte address = 4 * index
// Notes:   reserved bits are masked off on write and read back as zero
`default_nettype none
package ptrc_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          ADR_W    = 8;
  localparam int          DAT_W    = 32;
  localparam int          SEL_W    = 4;
  localparam int          REG_W    = 8;
  localparam int          NREG     = 5;
  localparam int          IDX_LSB  = 2;
  localparam int          IDX_W    = ADR_W - IDX_LSB;

  // ==========================================================================
  // register indices
  localparam logic [IDX_W-1:0] IDX_FAST_LOOP  = 6'h21;
  localparam logic [IDX_W-1:0] IDX_SYNC_PRE   = 6'h2B;
  localparam logic [IDX_W-1:0] IDX_PRE_LOW    = 6'h2C;
  localparam logic [IDX_W-1:0] IDX_LEN_ADDR   = 6'h2D;
  localparam logic [IDX_W-1:0] IDX_FORMAT     = 6'h2E;
  localparam logic [IDX_W-1:0] IDX_SUMMARY    = 6'h30;

  // slot order of the register array
  localparam int R_FAST = 0;
  localparam int R_SYNC = 1;
  localparam int R_PLOW = 2;
  localparam int R_LADR = 3;
  localparam int R_FMT  = 4;

  localparam logic [NREG-1:0][IDX_W-1:0] REG_IDX =
    {IDX_FORMAT, IDX_LEN_ADDR, IDX_PRE_LOW, IDX_SYNC_PRE, IDX_FAST_LOOP};
  localparam logic [NREG-1:0][REG_W-1:0] REG_RST =
    {8'h20, 8'h00, 8'h10, 8'h80, 8'h58};
  localparam logic [NREG-1:0][REG_W-1:0] REG_MASK =
    {8'hFC, 8'h88, 8'hFF, 8'hFF, 8'hFF};

  // ==========================================================================
  // field positions
  localparam int PGAIN_LSB = 5;
  localparam int PFLT_BIT  = 4;
  localparam int IGAIN_LSB = 0;
  localparam int SYNC_LSB  = 2;
  localparam int PREH_LSB  = 0;
  localparam int LWID_BIT  = 7;
  localparam int ADDR_BIT  = 3;
  localparam int FMT_LSB   = 6;
  localparam int RXM_LSB   = 4;
  localparam int SSWP_BIT  = 3;
  localparam int BSWP_BIT  = 2;
  localparam int HDR_LSB   = 0;
  localparam int RAWF_BIT  = 6;
  localparam int RAWP_BIT  = 7;

  // ==========================================================================
  // encodings
  typedef enum logic [1:0] {
    FMT_BASIC = 2'h0,
    FMT_G4    = 2'h1,
    FMT_UART  = 2'h2,
    FMT_STACK = 2'h3
  } ptrc_frame_e;

  localparam logic [1:0] RXM_NORMAL = 2'h0;
  localparam logic [1:0] RXM_FIFO   = 2'h1;
  localparam logic [1:0] RXM_PIN    = 2'h2;

  typedef struct packed {
    logic [2:0]  fast_loop_prop_gain;
    logic        post_filter_length;
    logic [3:0]  fast_loop_integral_gain;
    logic [5:0]  sync_field_bits;
    logic [9:0]  preamble_pair_count;
    logic        length_field_width;
    logic        address_field_include;
    ptrc_frame_e frame_format_select;
    logic [1:0]  rx_mode;
    logic        four_level_symbol_swap;
    logic        byte_swap;
  } ptrc_cfg_s;

endpackage
`default_nettype wire

// *** ptrc_cfg_reg.sv ***
// Purpose: one 8-bit configuration register with a write mask
// Assumes: single clock, asynchronous active-high reset
// Notes:   bits outside the mask never store and read as zero
`timescale 1ns/1ps
`default_nettype none
module ptrc_cfg_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);
  import ptrc_pkg::*;

  logic [7:0] value;
  logic [7:0] next_value;

  // ==========================================================================
  // storage
  always_comb begin
    next_value = value;
    if (we_i) begin
      next_value = wdata_i & WR_MASK;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      value <= RST_VAL & WR_MASK;
    end else begin
      value <= next_value;
    end
  end

  assign q_o = value;
endmodule
`default_nettype wire

// *** ptrc_tx_order.sv ***
// Purpose: apply bit order and 4-level symbol mapping to transmit data
// Assumes: serializer downstream always shifts bit 7 first
// Notes:   one cycle of latency, valid follows data
`timescale 1ns/1ps
`default_nettype none
module ptrc_tx_order (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       lsb_first_i,
  input  wire logic       sym_swap_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] byte_i,
  input  wire logic [1:0] sym_i,
  output logic            valid_o,
  output logic      [7:0] byte_o,
  output logic      [1:0] sym_o
);
  logic       valid_q;
  logic [7:0] byte_q;
  logic [1:0] sym_q;
  logic       next_valid;
  logic [7:0] next_byte;
  logic [1:0] next_sym;

  function automatic logic [7:0] rev_bits(input logic [7:0] b);
    logic [7:0] r;
    r = {<<{b}};
    return r;
  endfunction

  // ==========================================================================
  // reorder
  always_comb begin
    next_valid = valid_i;
    next_byte  = byte_q;
    next_sym   = sym_q;
    if (valid_i) begin
      next_byte = lsb_first_i ? rev_bits(byte_i) : byte_i;
      next_sym  = sym_swap_i ? ~sym_i : sym_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      byte_q  <= 8'h00;
      sym_q   <= 2'h0;
    end else begin
      valid_q <= next_valid;
      byte_q  <= next_byte;
      sym_q   <= next_sym;
    end
  end

  assign valid_o = valid_q;
  assign byte_o  = byte_q;
  assign sym_o   = sym_q;
endmodule
`default_nettype wire

// *** ptrc_top.sv ***
// Purpose: Wishbone register bank for fast-loop timing recovery and packet handler setup
// Assumes: classic Wishbone, 32-bit data, byte address = 4 * register index
// Notes:   registers sit in the low byte of each word, upper bytes read as zero
`timescale 1ns/1ps
`default_nettype none
module ptrc_top (
  input  wire logic                     CLK_I,
  input  wire logic                     SYS_RST_I,
  input  wire logic                     CYC_I,
  input  wire logic                     STB_I,
  input  wire logic                     WE_I,
  input  wire logic [ptrc_pkg::ADR_W-1:0] ADR_I,
  input  wire logic [ptrc_pkg::SEL_W-1:0] SEL_I,
  input  wire logic [ptrc_pkg::DAT_W-1:0] DAT_I,
  output logic      [ptrc_pkg::DAT_W-1:0] DAT_O,
  output logic                          ACK_O,
  input  wire logic                     PLL_SEL_I,
  input  wire logic                     TX_VALID_I,
  input  wire logic [7:0]               TX_BYTE_I,
  input  wire logic [1:0]               TX_SYM_I,
  output logic                          TX_VALID_O,
  output logic      [7:0]               TX_BYTE_O,
  output logic      [1:0]               TX_SYM_O,
  output ptrc_pkg::ptrc_cfg_s           CFG_O,
  output logic      [3:0]               INT_GAIN_EFF_O,
  output logic      [10:0]              PREAMBLE_BITS_O,
  output logic      [1:0]               HDR_BYTES_O,
  output logic                          RAW_FIFO_O,
  output logic                          RAW_PIN_O
);
  import ptrc_pkg::*;

  // ==========================================================================
  // address decode

  // one-hot register hit; bit NREG flags the read-only summary word
  function automatic logic [NREG:0] reg_hit(input logic [ADR_W-1:0] adr);
    logic [NREG:0] hit;
    hit = '0;
    if (adr[IDX_LSB-1:0] == 2'h0) begin
      for (int i = 0; i < NREG; i++) begin
        hit[i] = (adr[ADR_W-1:IDX_LSB] == REG_IDX[i]);
      end
      hit[NREG] = (adr[ADR_W-1:IDX_LSB] == IDX_SUMMARY);
    end
    return hit;
  endfunction

  // ==========================================================================
  // bus handshake

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ptrc_bus_e;

  ptrc_bus_e         bus_state;
  ptrc_bus_e         next_bus_state;
  logic [DAT_W-1:0]  rdata;
  logic [DAT_W-1:0]  next_rdata;
  logic [NREG:0]     hit;
  logic              req;
  logic              wr_take;
  logic [NREG-1:0]   reg_we;
  logic [REG_W-1:0]  reg_q [NREG];
  logic [REG_W-1:0]  summary;

  assign req = CYC_I & STB_I;
  assign hit = reg_hit(ADR_I);

  // a write lands once, on the edge where the master samples ack high; it
  // holds address and data until then, so storing earlier gains nothing
  assign wr_take = req & WE_I & SEL_I[0] & (bus_state == BUS_ACK);

  always_comb begin
    next_bus_state = bus_state;
    next_rdata     = rdata;
    unique case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ACK;
          next_rdata     = '0;
          for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
              next_rdata[REG_W-1:0] = reg_q[i];
            end
          end
          if (hit[NREG]) begin
            next_rdata[REG_W-1:0] = summary;
          end
        end
      end
      BUS_ACK: begin
        // ack drops for a cycle so back-to-back requests stay distinct
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      bus_state <= BUS_IDLE;
      rdata     <= '0;
    end else begin
      bus_state <= next_bus_state;
      rdata     <= next_rdata;
    end
  end

  assign ACK_O = (bus_state == BUS_ACK) & req;
  assign DAT_O = rdata;

  // ==========================================================================
  // register storage

  for (genvar g = 0; g < NREG; g++) begin : g_reg
    assign reg_we[g] = wr_take & hit[g];

    ptrc_cfg_reg #(
      .RST_VAL (REG_RST[g]),
      .WR_MASK (REG_MASK[g])
    ) u_reg (
      .clk_i   (CLK_I),
      .rst_i   (SYS_RST_I),
      .we_i    (reg_we[g]),
      .wdata_i (DAT_I[REG_W-1:0]),
      .q_o     (reg_q[g])
    );
  end

  // ==========================================================================
  // field extraction

  ptrc_cfg_s cfg;

  always_comb begin
    cfg = '0;
    cfg.fast_loop_prop_gain     = reg_q[R_FAST][PGAIN_LSB +: 3];
    cfg.post_filter_length      = reg_q[R_FAST][PFLT_BIT];
    cfg.fast_loop_integral_gain = reg_q[R_FAST][IGAIN_LSB +: 4];
    cfg.sync_field_bits         = reg_q[R_SYNC][SYNC_LSB +: 6];
    cfg.preamble_pair_count     = {reg_q[R_SYNC][PREH_LSB +: 2],
                                   reg_q[R_PLOW]};
    cfg.length_field_width      = reg_q[R_LADR][LWID_BIT];
    cfg.address_field_include   = reg_q[R_LADR][ADDR_BIT];
    cfg.frame_format_select     = ptrc_frame_e'(reg_q[R_FMT][FMT_LSB +: 2]);
    cfg.rx_mode                 = reg_q[R_FMT][RXM_LSB +: 2];
    cfg.four_level_symbol_swap  = reg_q[R_FMT][SSWP_BIT];
    cfg.byte_swap               = reg_q[R_FMT][BSWP_BIT];
  end

  assign CFG_O = cfg;

  // ==========================================================================
  // derived settings

  logic [3:0]  int_gain;
  logic [3:0]  next_int_gain;
  logic [10:0] pre_bits;
  logic [10:0] next_pre_bits;
  logic [1:0]  hdr_bytes;
  logic [1:0]  next_hdr_bytes;
  logic        raw_fifo;
  logic        next_raw_fifo;
  logic        raw_pin;
  logic        next_raw_pin;

  always_comb begin
    // the integral path is idle in DLL mode, so its gain is forced to zero
    next_int_gain  = PLL_SEL_I ? cfg.fast_loop_integral_gain : 4'h0;
    // each pair is two bits on air
    next_pre_bits  = {cfg.preamble_pair_count, 1'b0};
    // header bytes: the length field plus the optional one-byte address
    next_hdr_bytes = (cfg.length_field_width ? 2'h2 : 2'h1)
                   + {1'b0, cfg.address_field_include};
    // code 3 is undefined and falls back to normal packet handling
    next_raw_fifo  = (cfg.rx_mode == RXM_FIFO);
    next_raw_pin   = (cfg.rx_mode == RXM_PIN);
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      int_gain  <= 4'h0;
      pre_bits  <= 11'h000;
      hdr_bytes <= 2'h0;
      raw_fifo  <= 1'b0;
      raw_pin   <= 1'b0;
    end else begin
      int_gain  <= next_int_gain;
      pre_bits  <= next_pre_bits;
      hdr_bytes <= next_hdr_bytes;
      raw_fifo  <= next_raw_fifo;
      raw_pin   <= next_raw_pin;
    end
  end

  assign INT_GAIN_EFF_O  = int_gain;
  assign PREAMBLE_BITS_O = pre_bits;
  assign HDR_BYTES_O     = hdr_bytes;
  assign RAW_FIFO_O      = raw_fifo;
  assign RAW_PIN_O       = raw_pin;

  // ==========================================================================
  // summary readback

  always_comb begin
    summary = '0;
    summary[HDR_LSB +: 2] = hdr_bytes;
    summary[RAWF_BIT]     = raw_fifo;
    summary[RAWP_BIT]     = raw_pin;
  end

  // ==========================================================================
  // transmit ordering

  ptrc_tx_order u_order (
    .clk_i       (CLK_I),
    .rst_i       (SYS_RST_I),
    .lsb_first_i (cfg.byte_swap),
    .sym_swap_i  (cfg.four_level_symbol_swap),
    .valid_i     (TX_VALID_I),
    .byte_i      (TX_BYTE_I),
    .sym_i       (TX_SYM_I),
    .valid_o     (TX_VALID_O),
    .byte_o      (TX_BYTE_O),
    .sym_o       (TX_SYM_O)
  );

endmodule
`default_nettype wire

// *** ptrc_top_props.sv ***
// Purpose: concurrent checks on the config bank ports
// Assumes: one clock, async active-high reset
// Notes:   derived outputs are checked one cycle after their cause
`timescale 1ns/1ps
`default_nettype none
module ptrc_top_props
  import ptrc_pkg::*;
(
  input wire logic                 CLK_I,
  input wire logic                 SYS_RST_I,
  input wire logic                 CYC_I,
  input wire logic                 STB_I,
  input wire logic                 ACK_O,
  input wire logic                 PLL_SEL_I,
  input wire logic                 TX_VALID_I,
  input wire logic [7:0]           TX_BYTE_I,
  input wire logic [1:0]           TX_SYM_I,
  input wire logic                 TX_VALID_O,
  input wire logic [7:0]           TX_BYTE_O,
  input wire logic [1:0]           TX_SYM_O,
  input wire ptrc_pkg::ptrc_cfg_s  CFG_O,
  input wire logic [3:0]           INT_GAIN_EFF_O,
  input wire logic [10:0]          PREAMBLE_BITS_O,
  input wire logic [1:0]           HDR_BYTES_O
);
  // ==========================================================================
  // helpers
  // armed keeps $past away from values sampled while in reset
  logic armed;
  logic next_armed;
  always_comb next_armed = 1'b1;
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) armed <= 1'b0;
    else armed <= next_armed;
  end
  function automatic logic [7:0] rev8(input logic [7:0] b);
    rev8 = {<<{b}};
  endfunction
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_ack_pulse;
    ACK_O ##1 !ACK_O;
  endsequence
  // ==========================================================================
  // assertions
  a_ack_next: assert property (s_req |=> s_ack_pulse)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_tx_valid: assert property (armed |-> TX_VALID_O == $past(TX_VALID_I))
    else $error("tx valid not delayed by one");
  a_byte_order: assert property (armed && TX_VALID_O |-> TX_BYTE_O ==
    ($past(CFG_O.byte_swap) ? rev8($past(TX_BYTE_I)) : $past(TX_BYTE_I)))
    else $error("tx byte order wrong");
  a_sym_map: assert property (armed && TX_VALID_O |-> TX_SYM_O ==
    ($past(TX_SYM_I) ^ {2{$past(CFG_O.four_level_symbol_swap)}}))
    else $error("tx symbol mapping wrong");
  a_int_gain: assert property (armed |-> INT_GAIN_EFF_O ==
    ($past(PLL_SEL_I) ? $past(CFG_O.fast_loop_integral_gain) : 4'h0))
    else $error("integral gain gating wrong");
  a_preamble_bits: assert property (armed |-> PREAMBLE_BITS_O ==
    {$past(CFG_O.preamble_pair_count), 1'b0})
    else $error("preamble bit count wrong");
  a_hdr_bytes: assert property (armed |-> HDR_BYTES_O ==
    (($past(CFG_O.length_field_width) ? 2'h2 : 2'h1) +
     {1'b0, $past(CFG_O.address_field_include)}))
    else $error("header byte count wrong");
endmodule
bind ptrc_top ptrc_top_props u_ptrc_top_props (.CLK_I, .SYS_RST_I, .CYC_I, .STB_I,
  .ACK_O, .PLL_SEL_I, .TX_VALID_I, .TX_BYTE_I, .TX_SYM_I, .TX_VALID_O, .TX_BYTE_O,
  .TX_SYM_O, .CFG_O, .INT_GAIN_EFF_O, .PREAMBLE_BITS_O, .HDR_BYTES_O);
`default_nettype wire

// *** tb_ptrc_top.sv ***
// Purpose: self-checking bench for the config bank
// Assumes: reads and writes through classic Wishbone
// Notes:   register model mirrors every write, compared on each read
`timescale 1ns/1ps
`default_nettype none
module tb_ptrc_top;
  import ptrc_pkg::*;
  logic CLK_I = 0, SYS_RST_I = 1, CYC_I = 0, STB_I = 0, WE_I = 0;
  logic PLL_SEL_I = 0, TX_VALID_I = 0, ACK_O, TX_VALID_O, RAW_FIFO_O, RAW_PIN_O;
  logic [7:0]  ADR_I = 0, TX_BYTE_I = 0, TX_BYTE_O;
  logic [3:0]  SEL_I = 0, INT_GAIN_EFF_O;
  logic [31:0] DAT_I = 0, DAT_O;
  logic [1:0]  TX_SYM_I = 0, TX_SYM_O, HDR_BYTES_O;
  logic [10:0] PREAMBLE_BITS_O;
  ptrc_cfg_s   CFG_O;
  int m[NREG];
  int fail_count = 0, tests_run = 0, seed = 32'hB6B0759B;
  ptrc_top u_ptrc_top (.CLK_I, .SYS_RST_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I,
    .DAT_I, .DAT_O, .ACK_O, .PLL_SEL_I, .TX_VALID_I, .TX_BYTE_I, .TX_SYM_I,
    .TX_VALID_O, .TX_BYTE_O, .TX_SYM_O, .CFG_O, .INT_GAIN_EFF_O,
    .PREAMBLE_BITS_O, .HDR_BYTES_O, .RAW_FIFO_O, .RAW_PIN_O);
  always #50 CLK_I = ~CLK_I;
  // ==========================================================================
  // checking and model
  task print_verdict;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function int hdr();
    return (m[R_LADR][7] ? 2 : 1) + m[R_LADR][3];
  endfunction
  function logic [31:0] exp_rd(input logic [7:0] a);
    if (a[1:0] != 2'h0) return 0;
    for (int i = 0; i < NREG; i++) if (a[7:2] == REG_IDX[i]) return m[i];
    // summary is the only read-only place, everything else reads zero
    if (a[7:2] == IDX_SUMMARY)
      return hdr() | ((m[R_FMT][5:4] == 1) << 6) | ((m[R_FMT][5:4] == 2) << 7);
    return 0;
  endfunction
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic s);
    int n;
    @(posedge CLK_I);
    CYC_I <= 1;
    STB_I <= 1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= d;
    SEL_I <= {3'($random(seed)), s};
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    if (ACK_O !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    if (!w) chk(DAT_O, exp_rd(a));
    else if (s && a[1:0] == 2'h0)
      for (int i = 0; i < NREG; i++)
        if (a[7:2] == REG_IDX[i]) m[i] = d[7:0] & REG_MASK[i];
    CYC_I <= 0;
    STB_I <= 0;
  endtask
  task chk_cfg;
    int p;
    p = {m[R_SYNC][1:0], m[R_PLOW][7:0]};
    chk(CFG_O.fast_loop_prop_gain, m[R_FAST][7:5]);
    chk(CFG_O.fast_loop_integral_gain, m[R_FAST][3:0]);
    chk(CFG_O.post_filter_length, m[R_FAST][4]);
    chk(INT_GAIN_EFF_O, PLL_SEL_I ? m[R_FAST][3:0] : 0);
    chk(CFG_O.sync_field_bits, m[R_SYNC][7:2]);
    chk(CFG_O.preamble_pair_count, p);
    chk(PREAMBLE_BITS_O, 2 * p);
    chk(CFG_O.length_field_width, m[R_LADR][7]);
    chk(CFG_O.address_field_include, m[R_LADR][3]);
    chk(HDR_BYTES_O, hdr());
    chk(CFG_O.frame_format_select, m[R_FMT][7:6]);
    chk(CFG_O.rx_mode, m[R_FMT][5:4]);
    chk({RAW_PIN_O, RAW_FIFO_O}, {m[R_FMT][5:4] == 2, m[R_FMT][5:4] == 1});
    chk(CFG_O.four_level_symbol_swap, m[R_FMT][3]);
    chk(CFG_O.byte_swap, m[R_FMT][2]);
  endtask
  task automatic tx_burst;
    logic [7:0] b, r;
    logic [1:0] s;
    logic v;
    logic [10:0] x;
    logic [10:0] q[$];
    for (int j = 0; j <= 8; j++) begin
      @(posedge CLK_I);
      v = j < 8 && $random(seed) % 4 != 0;
      b = $random(seed);
      s = $random(seed);
      r = {<<{b}};
      TX_VALID_I <= v;
      TX_BYTE_I <= b;
      TX_SYM_I <= s;
      q.push_back({v, m[R_FMT][2] ? r : b, s ^ {2{m[R_FMT][3]}}});
      @(negedge CLK_I);
      if (j > 0) begin
        x = q.pop_front();
        chk(TX_VALID_O, x[10]);
        if (x[10]) chk(TX_BYTE_O, x[9:2]);
        if (x[10]) chk(TX_SYM_O, x[1:0]);
      end
    end
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    int k;
    logic [7:0] a;
    repeat (20) @(posedge CLK_I);
    SYS_RST_I <= 0;
    for (int i = 0; i < NREG; i++) m[i] = REG_RST[i];
    repeat (2) @(negedge CLK_I);
    chk_cfg();
    for (int i = 0; i < NREG; i++) bus(0, {REG_IDX[i], 2'h0}, 0, 1);
    bus(0, {IDX_SUMMARY, 2'h0}, 0, 1);
    // random writes hit registers, the read-only summary, holes and odd addresses
    repeat (60) begin
      @(posedge CLK_I);
      PLL_SEL_I <= 1'($random(seed));
      k = $random(seed) & 7;
      a = k < 5 ? {REG_IDX[k], 2'h0} : k == 5 ? {IDX_SUMMARY, 2'h0} :
          k == 6 ? 8'h00 : {IDX_SYNC_PRE, 2'h2};
      bus(1, a, $random(seed), $random(seed) % 4 != 0);
      bus(0, a, 0, 1);
      @(negedge CLK_I);
      chk_cfg();
    end
    for (int f = 0; f < 4; f++) begin
      bus(1, {IDX_FORMAT, 2'h0}, {f[1:0], f[1:0], f[0], f[1], 2'h3}, 1);
      bus(0, {IDX_SUMMARY, 2'h0}, 0, 1);
      @(negedge CLK_I);
      chk_cfg();
      tx_burst();
    end
    // mid-run reset must bring every setting back to its reset value
    @(posedge CLK_I);
    SYS_RST_I <= 1;
    repeat (3) @(posedge CLK_I);
    SYS_RST_I <= 0;
    for (int i = 0; i < NREG; i++) m[i] = REG_RST[i];
    repeat (2) @(negedge CLK_I);
    chk_cfg();
    for (int i = 0; i < NREG; i++) bus(0, {REG_IDX[i], 2'h0}, 0, 1);
    print_verdict();
  end
endmodule
`default_nettype wire
